// file: logic/i2c_port_pkg.sv
package i2c_port_pkg;

   localparam int             DATA_W     = 8;
   localparam logic [6:0]     SLAVE_ADDR = 7'h57;
   localparam logic [3:0]     CNT_ZERO   = 4'h0;
   localparam logic [3:0]     BYTE_BITS  = 4'h8;
   localparam logic [3:0]     FRAME_BITS = 4'h9;
   localparam logic [7:0]     PTR_RESET  = 8'h00;
   localparam logic [7:0]     PTR_STEP   = 8'h01;
   localparam logic [7:0]     DATA_RESET = 8'h00;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_PTR,
      ST_WDATA,
      ST_RFIRST,
      ST_RDATA,
      ST_IGNORE
   } link_state_e;

   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] data;
   } reg_req_s;

   localparam reg_req_s REQ_RESET = '{wr: 1'h0, addr: 8'h00, data: 8'h00};

endpackage

// file: logic/cdc_sync.sv
`timescale 1ns/1ps
module cdc_sync #(
   parameter logic RESET_VAL = 1'h0
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic d_i,
   output logic      q_o
);

   logic meta;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         meta <= RESET_VAL;
         q_o  <= RESET_VAL;
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end

endmodule

// file: logic/i2c_slave_register_port.sv
`timescale 1ns/1ps
// Contract
// R1: The master starts every transfer and makes the serial clock.
// R2: The clock line is only an input and is never driven.
// R3: Data line is sampled; only pulled low or released, never driven high.
// R4: Transfer is START, address with direction, pointer byte, data bytes, STOP.
// R5: Both lines stay released and high while the bus is idle.
// R6: Data falling while clock high is START and is recognised.
// R7: Data rising while clock high is STOP; bus is then free.
// R8: One bit per clock pulse; data stable while clock is high.
// R9: Ninth pulse carries acknowledge, receiver holds data low.
// R10: Device acknowledges bytes it receives; master acknowledges bytes it gets.
// R11: Data high in the ninth slot means not-acknowledge.
// R12: Only the fixed address 1010111 after START is answered.
// R13: Direction bit zero writes, one reads from the device.
// R14: Any START, repeated ones included, resets the bus interface state.
// R15: First byte after address in a write is stored as pointer.
// R16: STOP after pointer byte only keeps the pointer, writes nothing.
// R17: Each later data byte is written at pointer, then pointer increments.
// R18: Reads return the pointed register, pointer increments per byte sent.
// R19: Master sets pointer by write, then repeated START to read.
// R20: After master not-acknowledge the device releases data and stops sending.
// R21: Pointer is eight bits; address mismatch leaves data released until START.
// R22: Both lines are synchronised and edge detected before decoding.
module i2c_slave_register_port
   import i2c_port_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              link_clk_i,
   input  wire logic              scl_i,  // R2
   input  wire logic              sda_i,
   output logic                   sda_o,
   output logic                   sda_oe_o,
   output logic                   reg_wr_o,
   output logic                   reg_rd_o,
   output logic [DATA_W-1:0]      reg_addr_o,
   output logic [DATA_W-1:0]      reg_wdata_o,
   input  wire logic [DATA_W-1:0] reg_rdata_i
);

   logic              link_rst_n;
   logic              scl_s;
   logic              sda_s;
   logic              scl_q;
   logic              sda_q;
   logic              start_c;
   logic              stop_c;
   logic              rise_c;
   logic              fall_c;
   logic              byte_end;
   logic              slot_end;
   logic              mack_rise;
   logic              addr_hit;
   logic              busy;
   logic              load_pending;
   logic [3:0]        cnt;
   logic [7:0]        shreg;
   logic [7:0]        txsh;
   logic [7:0]        pointer;
   link_state_e       state;
   logic              req_tog;
   logic              ack_sync;
   reg_req_s          req;
   logic              req_sync;
   logic              req_seen;
   logic              ack_tog;
   logic [1:0]        rd_wait;
   logic [7:0]        rd_data;

   // Link domain reset and line synchronisers
   cdc_sync #(.RESET_VAL(1'h0)) u_rst_sync (
      .clk_i   (link_clk_i),
      .rst_n_i (1'h1),
      .d_i     (rst_n_i),
      .q_o     (link_rst_n)
   );
   cdc_sync #(.RESET_VAL(1'h1)) u_scl_sync (  // R22
      .clk_i   (link_clk_i),
      .rst_n_i (link_rst_n),
      .d_i     (scl_i),
      .q_o     (scl_s)
   );
   cdc_sync #(.RESET_VAL(1'h1)) u_sda_sync (  // R22
      .clk_i   (link_clk_i),
      .rst_n_i (link_rst_n),
      .d_i     (sda_i),
      .q_o     (sda_s)
   );
   cdc_sync #(.RESET_VAL(1'h0)) u_ack_sync (
      .clk_i   (link_clk_i),
      .rst_n_i (link_rst_n),
      .d_i     (ack_tog),
      .q_o     (ack_sync)
   );
   cdc_sync #(.RESET_VAL(1'h0)) u_req_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     (req_tog),
      .q_o     (req_sync)
   );

   always_ff @(posedge link_clk_i) begin
      if (!link_rst_n) begin
         scl_q <= 1'h1;
         sda_q <= 1'h1;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   always_comb begin
      start_c   = scl_s && scl_q && sda_q && !sda_s;  // R6 R8
      stop_c    = scl_s && scl_q && !sda_q && sda_s;  // R7 R8
      rise_c    = scl_s && !scl_q;
      fall_c    = !scl_s && scl_q;
      byte_end  = fall_c && (cnt == BYTE_BITS);
      slot_end  = fall_c && (cnt == FRAME_BITS);
      mack_rise = rise_c && (cnt == BYTE_BITS) && (state == ST_RDATA);
      addr_hit  = (shreg[7:1] == SLAVE_ADDR);  // R12
      busy      = req_tog ^ ack_sync;
   end

   // Bit counter: eight data rises, then the acknowledge rise
   always_ff @(posedge link_clk_i) begin
      if (!link_rst_n || start_c || stop_c) begin
         cnt <= CNT_ZERO;  // R14
      end else if (slot_end) begin
         cnt <= CNT_ZERO;  // R9
      end else if (rise_c && (cnt != FRAME_BITS)) begin
         cnt <= cnt + 4'h1;  // R8
      end
   end

   always_ff @(posedge link_clk_i) begin
      if (!link_rst_n) begin
         shreg <= DATA_RESET;
      end else if (rise_c && (cnt < BYTE_BITS)) begin
         shreg <= {shreg[6:0], sda_s};  // R8
      end
   end

   always_ff @(posedge link_clk_i) begin
      if (!link_rst_n) begin
         state <= ST_IDLE;
      end else if (start_c) begin
         state <= ST_ADDR;  // R4 R14
      end else if (stop_c) begin
         state <= ST_IDLE;  // R7 R16
      end else begin
         unique case (state)
            ST_IDLE: begin
               state <= ST_IDLE;
            end
            ST_ADDR: begin
               if (byte_end) begin
                  if (!addr_hit) begin
                     state <= ST_IGNORE;  // R21
                  end else if (shreg[0]) begin
                     state <= ST_RFIRST;  // R13
                  end else begin
                     state <= ST_PTR;  // R13
                  end
               end
            end
            ST_PTR: begin
               if (byte_end) begin
                  state <= ST_WDATA;  // R15
               end
            end
            ST_WDATA: begin
               state <= ST_WDATA;
            end
            ST_RFIRST: begin
               if (slot_end) begin
                  state <= ST_RDATA;
               end
            end
            ST_RDATA: begin
               if (mack_rise && sda_s) begin
                  state <= ST_IGNORE;  // R11 R20
               end
            end
            ST_IGNORE: begin
               state <= ST_IGNORE;  // R21
            end
         endcase
      end
   end

   always_ff @(posedge link_clk_i) begin
      if (!link_rst_n) begin
         pointer <= PTR_RESET;
      end else if (byte_end && (state == ST_PTR)) begin
         pointer <= shreg;  // R15
      end else if (byte_end && (state == ST_WDATA)) begin
         pointer <= pointer + PTR_STEP;  // R17
      end else if (mack_rise) begin
         pointer <= pointer + PTR_STEP;  // R18
      end
   end

   // Register requests handed to the system clock domain
   always_ff @(posedge link_clk_i) begin
      if (!link_rst_n) begin
         req_tog <= 1'h0;
         req     <= REQ_RESET;
      end else if (byte_end && (state == ST_WDATA)) begin
         req_tog <= !req_tog;
         req     <= '{wr: 1'h1, addr: pointer, data: shreg};  // R17
      end else if (byte_end && (state == ST_ADDR) && addr_hit && shreg[0]) begin
         req_tog <= !req_tog;
         req     <= '{wr: 1'h0, addr: pointer, data: DATA_RESET};  // R18
      end else if (mack_rise && !sda_s) begin
         req_tog <= !req_tog;
         req     <= '{wr: 1'h0, addr: pointer + PTR_STEP, data: DATA_RESET};  // R18
      end
   end

   // Open-drain data drive: acknowledge and transmit bits
   always_ff @(posedge link_clk_i) begin
      if (!link_rst_n) begin
         sda_o        <= 1'h0;
         sda_oe_o     <= 1'h0;  // R5
         txsh         <= DATA_RESET;
         load_pending <= 1'h0;
      end else begin
         sda_o <= 1'h0;  // R3
         if (start_c || stop_c) begin
            sda_oe_o     <= 1'h0;  // R5 R14
            load_pending <= 1'h0;
         end else if (byte_end) begin
            sda_oe_o <= ((state == ST_ADDR) && addr_hit) ||
                        (state == ST_PTR) || (state == ST_WDATA);  // R9 R10
         end else if (slot_end) begin
            if ((state == ST_RFIRST) || (state == ST_RDATA)) begin
               if (busy) begin
                  sda_oe_o     <= 1'h0;
                  load_pending <= 1'h1;
               end else begin
                  sda_oe_o <= !rd_data[7];  // R3 R18
                  txsh     <= {rd_data[6:0], 1'h0};
               end
            end else begin
               sda_oe_o <= 1'h0;  // R9
            end
         end else if (load_pending && !busy) begin
            sda_oe_o     <= !rd_data[7];
            txsh         <= {rd_data[6:0], 1'h0};
            load_pending <= 1'h0;
         end else if (fall_c && (state == ST_RDATA) && (cnt != CNT_ZERO)) begin
            sda_oe_o <= !txsh[7];  // R8
            txsh     <= {txsh[6:0], 1'h0};
         end
      end
   end

   // System side: registered strobes toward the register bank
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         req_seen    <= 1'h0;
         ack_tog     <= 1'h0;
         rd_wait     <= 2'h0;
         rd_data     <= DATA_RESET;
         reg_wr_o    <= 1'h0;
         reg_rd_o    <= 1'h0;
         reg_addr_o  <= PTR_RESET;
         reg_wdata_o <= DATA_RESET;
      end else begin
         reg_wr_o <= 1'h0;
         reg_rd_o <= 1'h0;
         rd_wait  <= {rd_wait[0], 1'h0};
         if (rd_wait[1]) begin
            rd_data <= reg_rdata_i;  // R18
            ack_tog <= !ack_tog;
         end else if ((req_sync != req_seen) && !rd_wait[0]) begin
            req_seen   <= req_sync;
            reg_addr_o <= req.addr;
            if (req.wr) begin
               reg_wr_o    <= 1'h1;  // R17
               reg_wdata_o <= req.data;
               ack_tog     <= !ack_tog;
            end else begin
               reg_rd_o <= 1'h1;
               rd_wait  <= 2'h1;
            end
         end
      end
   end

   sda_low_only_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)  // R3
      sda_oe_o |-> (sda_o == 1'h0))
      else $error("data line driven high");
   start_reset_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)  // R14
      start_c |=> (state == ST_ADDR) && !sda_oe_o && (cnt == CNT_ZERO))
      else $error("start did not reset interface");
   stop_free_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)  // R7
      stop_c |=> (state == ST_IDLE) && !sda_oe_o)
      else $error("stop did not free bus");
   addr_ack_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)  // R12
      (byte_end && (state == ST_ADDR) && addr_hit) |=> sda_oe_o throughout (!fall_c [*2]))
      else $error("own address not acknowledged");
   mismatch_quiet_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)  // R21
      (state == ST_IGNORE) && !start_c |=> !sda_oe_o)
      else $error("driving after address mismatch");
   ptr_store_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)  // R15
      (byte_end && (state == ST_PTR)) |=> (pointer == $past(shreg)) && (state == ST_WDATA))
      else $error("pointer byte not stored");
   wr_incr_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)  // R17
      (byte_end && (state == ST_WDATA)) |=>
         (pointer == 8'($past(pointer) + PTR_STEP)) && req.wr && (req.addr == $past(pointer)))
      else $error("write did not use and step pointer");
   nack_release_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)  // R20
      (mack_rise && sda_s) |=> (state == ST_IGNORE) ##0 (!sda_oe_o [*3]))
      else $error("data driven after not-acknowledge");
   wr_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // R17
      $rose(reg_wr_o) |=> !reg_wr_o && !reg_rd_o)
      else $error("write strobe longer than one cycle");
   rd_return_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // R18
      reg_rd_o |-> ##2 ((rd_data == $past(reg_rdata_i)) && (ack_tog != $past(ack_tog))))
      else $error("read data not captured");

   write_seen_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) reg_wr_o);
   read_seen_c: cover property (@(posedge link_clk_i) disable iff (!link_rst_n)
      slot_end && (state == ST_RFIRST));
   nack_seen_c: cover property (@(posedge link_clk_i) disable iff (!link_rst_n)
      mack_rise && sda_s);
   mismatch_seen_c: cover property (@(posedge link_clk_i) disable iff (!link_rst_n)
      state == ST_IGNORE);

endmodule

// file: testbench/i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model (
   output logic      scl_o,
   output logic      sda_low_o,
   input  wire logic sda_i
);
   localparam time Q = 625ns;

   initial begin
      scl_o     = 1'b1;
      sda_low_o = 1'b0;
   end

   // Also serves as repeated start from a low clock
   task automatic start_cond();
      sda_low_o = 1'b0;
      #Q;
      scl_o = 1'b1;
      #Q;
      sda_low_o = 1'b1;
      #Q;
      scl_o = 1'b0;
      #Q;
   endtask

   task automatic stop_cond();
      sda_low_o = 1'b1;
      #Q;
      scl_o = 1'b1;
      #Q;
      sda_low_o = 1'b0;
      #Q;
   endtask

   task automatic put_bit(input logic b);
      sda_low_o = ~b;
      #Q;
      scl_o = 1'b1;
      #(2*Q);
      scl_o = 1'b0;
      #Q;
   endtask

   task automatic get_bit(output logic b);
      sda_low_o = 1'b0;
      #Q;
      scl_o = 1'b1;
      #Q;
      b = sda_i;
      #Q;
      scl_o = 1'b0;
      #Q;
   endtask

   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         put_bit(d[i]);
      end
      get_bit(b);
      ack = ~b;
   endtask

   task automatic recv_byte(input logic ack, output logic [7:0] d);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         get_bit(b);
         d[i] = b;
      end
      put_bit(~ack);
   endtask
endmodule

// file: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
   import i2c_port_pkg::*;
   logic       clk_i, rst_n_i, link_clk_i, scl, m_low, sda;
   logic       sda_o, sda_oe_o, reg_wr_o, reg_rd_o;
   logic [7:0] reg_addr_o, reg_wdata_o, reg_rdata_i;
   logic [7:0] bank   [256];
   logic [7:0] golden [256];
   int         mismatches, n_compared, n_wr;

   // Open-drain wire with pull-up
   assign sda = !((sda_oe_o === 1'b1 && sda_o === 1'b0) || m_low === 1'b1);

   i2c_slave_register_port i_i2c_slave_register_port (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i), .scl_i(scl),
      .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .reg_wr_o(reg_wr_o),
      .reg_rd_o(reg_rd_o), .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o),
      .reg_rdata_i(reg_rdata_i)
   );
   i2c_master_model i_i2c_master_model (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   initial begin
      link_clk_i = 1'b0;
      #17;
      forever #62.5 link_clk_i = ~link_clk_i;
   end

   // Register bank; read data valid only in the cycle after the strobe
   always @(posedge clk_i) begin
      if (reg_wr_o === 1'b1) begin
         bank[reg_addr_o] <= reg_wdata_o;
         n_wr <= n_wr + 1;
      end
      if (reg_rd_o === 1'b1) begin
         reg_rdata_i <= bank[reg_addr_o];
      end else begin
         reg_rdata_i <= ~reg_rdata_i;
      end
   end

   function automatic logic [7:0] addr_byte(input logic rw);
      return {SLAVE_ADDR, rw};
   endfunction

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr_hdr(input logic [7:0] p);
      logic ack;
      i_i2c_master_model.start_cond();
      i_i2c_master_model.send_byte(addr_byte(1'b0), ack);
      check("ack write address", 8'h01, {7'h00, ack});
      i_i2c_master_model.send_byte(p, ack);
      check("ack pointer", 8'h01, {7'h00, ack});
   endtask

   // Read n bytes from pointer p, last one answered with not-acknowledge
   task automatic rd_check(input logic [7:0] p, input int n);
      logic       ack;
      logic [7:0] d;
      i_i2c_master_model.send_byte(addr_byte(1'b1), ack);
      check("ack read address", 8'h01, {7'h00, ack});
      for (int k = 0; k < n; k++) begin
         i_i2c_master_model.recv_byte(k < n - 1, d);
         check("read data", golden[8'(p + k)], d);
      end
      check("sda released", 8'h01, {7'h00, sda});
      i_i2c_master_model.stop_cond();
   endtask

   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      #480us;
      mismatches++;
      close_out();
   end

   initial begin
      logic       ack;
      logic [7:0] d, q;
      logic [6:0] bad;
      int         wr_before;
      rst_n_i     = 1'b0;
      reg_rdata_i = 8'h00;
      n_wr        = 0;
      void'($urandom(32'h7236));
      for (int i = 0; i < 256; i++) begin
         bank[i]   = 8'($urandom);
         golden[i] = bank[i];
      end
      // Long enough for the link domain to see reset
      repeat (80) @(posedge clk_i);
      rst_n_i <= 1'b1;
      #1us;
      check("idle sda", 8'h01, {7'h00, sda});
      // Burst write across pointer wrap
      wr_hdr(8'hff);
      for (int k = 0; k < 2; k++) begin
         d = 8'($urandom);
         golden[8'(8'hff + k)] = d;
         i_i2c_master_model.send_byte(d, ack);
         check("ack data", 8'h01, {7'h00, ack});
      end
      i_i2c_master_model.stop_cond();
      #1us;
      check("wrap write count", 8'h02, 8'(n_wr));
      // Foreign address, then repeated start with pointer only
      bad = 7'($urandom);
      if (bad == SLAVE_ADDR) bad = bad ^ 7'h01;
      wr_before = n_wr;
      i_i2c_master_model.start_cond();
      i_i2c_master_model.send_byte({bad, 1'b0}, ack);
      check("nack foreign", 8'h00, {7'h00, ack});
      i_i2c_master_model.send_byte(8'h00, ack);
      check("silent after miss", 8'h00, {7'h00, ack});
      q = 8'($urandom);
      wr_hdr(q);
      i_i2c_master_model.stop_cond();
      #1us;
      check("pointer-only writes", 8'(wr_before), 8'(n_wr));
      // Read at stored pointer
      i_i2c_master_model.start_cond();
      rd_check(q, 1);
      // Pointer write, repeated start, two-byte read
      q = 8'($urandom);
      wr_hdr(q);
      i_i2c_master_model.start_cond();
      rd_check(q, 2);
      for (int i = 0; i < 256; i++) begin
         check("bank", golden[i], bank[i]);
      end
      close_out();
   end
endmodule
